// ===== common/rcs_pkg.sv
// rcs_pkg: shared constants of the real-time clock control/status register block
// assumes: byte-wide register access port, one 125 MHz clock
package rcs_pkg;

    // ------------------------------------------------------------
    // register indices on the byte access port
    // ------------------------------------------------------------
    localparam logic [6:0] RCS_ADDR_RATE    = 7'h0a;   // rate select and update pending
    localparam logic [6:0] RCS_ADDR_CONTROL = 7'h0b;   // rtc_control
    localparam logic [6:0] RCS_ADDR_FLAGS   = 7'h0c;   // irq_flag_status
    localparam logic [6:0] RCS_ADDR_BATTERY = 7'h0d;   // battery_status

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RCS_BIT_FREEZE   = 7;    // update freeze in rtc_control
    localparam int RCS_BIT_PERIODIC = 6;    // periodic enable / periodic flag
    localparam int RCS_BIT_ALARM    = 5;    // alarm enable / alarm flag
    localparam int RCS_BIT_UPDATE   = 4;    // update-done enable / update-done flag
    localparam int RCS_BIT_SQUARE   = 3;    // square output enable
    localparam int RCS_BIT_FORMAT   = 2;    // binary when one, bcd when zero
    localparam int RCS_BIT_HOUR24   = 1;    // 24-hour when one
    localparam int RCS_BIT_SUMMER   = 0;    // summer time enable
    localparam int RCS_BIT_COMBINED = 7;    // combined request flag
    localparam int RCS_BIT_VALID    = 7;    // battery valid
    localparam int RCS_BIT_PENDING  = 7;    // update pending in rate register

    // ------------------------------------------------------------
    // values after reset and divider shape
    // ------------------------------------------------------------
    localparam logic [7:0]  RCS_BYTE_ZERO    = 8'h00;
    localparam logic [3:0]  RCS_RATE_RESET   = 4'h0;   // no tap selected
    localparam logic [3:0]  RCS_RATE_NONE    = 4'h0;
    localparam logic [3:0]  RCS_RATE_256HZ   = 4'h1;
    localparam logic [3:0]  RCS_RATE_128HZ   = 4'h2;
    localparam logic [3:0]  RCS_RATE_FAST    = 4'h3;   // first of the binary-spaced codes
    localparam int          RCS_DIV_STAGES   = 15;
    localparam logic [3:0]  RCS_TAP_256HZ    = 4'h6;
    localparam logic [3:0]  RCS_TAP_128HZ    = 4'h7;
    localparam logic [3:0]  RCS_TAP_OFFSET   = 4'h2;   // code minus this is the tap index
    localparam logic [14:0] RCS_DIV_RESET    = 15'h0000;

endpackage : rcs_pkg

// ===== rtl/rcs_rate_div.sv
// rcs_rate_div: 15-stage divider on the oscillator tick, tap selector, square output
// assumes: osc_tick is a one-cycle pulse at the 32.768 kHz oscillator rate
`timescale 1ns/100ps
module rcs_rate_div
    import rcs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       osc_tick,
    input  wire logic [3:0] rate_select,
    input  wire logic       square_out_enable,
    output logic            tap_edge,
    output logic            square_out_pin
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [14:0] div_count;        // divider chain
    logic [14:0] next_div_count;
    logic        tap_prev;         // selected tap, one cycle old
    logic        next_tap_prev;
    logic        next_tap_edge;
    logic        next_square;
    logic        tap_level;        // current selected tap

    // tap index for a code; code zero never reaches here
    function automatic logic [3:0] tap_index(input logic [3:0] code);
        if (code == RCS_RATE_256HZ) begin
            tap_index = RCS_TAP_256HZ;
        end else if (code == RCS_RATE_128HZ) begin
            tap_index = RCS_TAP_128HZ;
        end else begin
            tap_index = code - RCS_TAP_OFFSET;
        end
    endfunction : tap_index

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    // the divider runs free so switching codes never restarts the chain
    always_comb begin
        next_div_count = osc_tick ? div_count + 15'h0001 : div_count;
        if (rate_select == RCS_RATE_NONE) begin
            tap_level = 1'b0;
        end else begin
            tap_level = div_count[tap_index(rate_select)];
        end
        next_tap_prev = tap_level;
        next_tap_edge = tap_level & ~tap_prev;
        next_square   = square_out_enable & tap_level;
    end

    // registers only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_count      <= RCS_DIV_RESET;
            tap_prev       <= 1'b0;
            tap_edge       <= 1'b0;
            square_out_pin <= 1'b0;
        end else begin
            div_count      <= next_div_count;
            tap_prev       <= next_tap_prev;
            tap_edge       <= next_tap_edge;
            square_out_pin <= next_square;
        end
    end

endmodule : rcs_rate_div

// ===== rtl/rcs_ctrl_regs.sv
// rcs_ctrl_regs: control, interrupt flag, battery and rate registers of the clock
// assumes: bus strobes are one-cycle pulses synchronous to ref_clk; the time chain
// reports update start/end as pulses and presents the user time and alarm bytes
`timescale 1ns/100ps
module rcs_ctrl_regs
    import rcs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,              // reset pin
    input  wire logic       pwr_on_rstn,       // power-up only reset
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    input  wire logic [6:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    input  wire logic       osc_tick,
    input  wire logic       update_start,
    input  wire logic       update_end,
    input  wire logic [7:0] time_sec,
    input  wire logic [7:0] time_min,
    input  wire logic [7:0] time_hour,
    input  wire logic [7:0] alarm_sec,
    input  wire logic [7:0] alarm_min,
    input  wire logic [7:0] alarm_hour,
    input  wire logic       battery_good,
    output logic            irq_n,
    output logic            square_out_pin,
    output logic            update_transfer_en,
    output logic            number_format_select,
    output logic            hour_24_select,
    output logic            summer_time_enable
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic       update_freeze;          // survives the reset pin
    logic       next_update_freeze;
    logic       periodic_irq_enable;    // cleared by reset pin
    logic       next_periodic_irq_enable;
    logic       alarm_irq_enable;
    logic       next_alarm_irq_enable;
    logic       update_done_irq_enable;
    logic       next_update_done_irq_enable;
    logic       square_out_enable;
    logic       next_square_out_enable;
    logic       next_number_format_select;
    logic       next_hour_24_select;
    logic       next_summer_time_enable;
    logic [3:0] rate_select;            // not touched by the reset pin
    logic [3:0] next_rate_select;
    logic       update_pending_flag;
    logic       next_update_pending_flag;
    logic       battery_valid;
    logic       periodic_flag;
    logic       next_periodic_flag;
    logic       alarm_match_flag;
    logic       next_alarm_match_flag;
    logic       update_done_flag;
    logic       next_update_done_flag;
    logic       combined_request_flag;  // decoded from flags and enables
    logic       next_irq_n;
    logic [7:0] next_bus_rdata;
    logic       next_update_transfer_en;
    logic       tap_edge;               // periodic event from the divider
    logic       wr_control;
    logic       wr_rate;
    logic       rd_flags;
    logic       alarm_hit;

    // alarm byte matches on equality or the don't-care code
    function automatic logic byte_match(input logic [7:0] alarm, input logic [7:0] now);
        byte_match = alarm[7] | (alarm == now);
    endfunction : byte_match

    // ------------------------------------------------------------
    // divider and square output
    // ------------------------------------------------------------
    // shared tap
    rcs_rate_div u_rate_div (
        .ref_clk           (ref_clk),
        .rstn              (rstn),
        .osc_tick          (osc_tick),
        .rate_select       (rate_select),
        .square_out_enable (square_out_enable),
        .tap_edge          (tap_edge),
        .square_out_pin    (square_out_pin)
    );

    // ------------------------------------------------------------
    // control register next values
    // ------------------------------------------------------------
    // enables follow software writes, except that setting freeze clears the update-done enable; freeze only ever changes by a write
    always_comb begin
        wr_control = bus_wr && (bus_addr == RCS_ADDR_CONTROL);
        wr_rate    = bus_wr && (bus_addr == RCS_ADDR_RATE);
        next_update_freeze          = update_freeze;
        next_periodic_irq_enable    = periodic_irq_enable;
        next_alarm_irq_enable       = alarm_irq_enable;
        next_update_done_irq_enable = update_done_irq_enable;
        next_square_out_enable      = square_out_enable;
        next_number_format_select   = number_format_select;
        next_hour_24_select         = hour_24_select;
        next_summer_time_enable     = summer_time_enable;
        next_rate_select            = rate_select;
        if (wr_control) begin
            next_update_freeze          = bus_wdata[RCS_BIT_FREEZE];
            next_periodic_irq_enable    = bus_wdata[RCS_BIT_PERIODIC];
            next_alarm_irq_enable       = bus_wdata[RCS_BIT_ALARM];
            next_update_done_irq_enable = bus_wdata[RCS_BIT_UPDATE];
            next_square_out_enable      = bus_wdata[RCS_BIT_SQUARE];
            next_number_format_select   = bus_wdata[RCS_BIT_FORMAT];
            next_hour_24_select         = bus_wdata[RCS_BIT_HOUR24];
            next_summer_time_enable     = bus_wdata[RCS_BIT_SUMMER];
            if (bus_wdata[RCS_BIT_FREEZE] && !update_freeze) begin
                next_update_done_irq_enable = 1'b0;
            end
        end
        if (wr_rate) begin
            next_rate_select = bus_wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // control register storage
    // ------------------------------------------------------------
    // reset-pin clear; square enable clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            periodic_irq_enable    <= 1'b0;
            alarm_irq_enable       <= 1'b0;
            update_done_irq_enable <= 1'b0;
            square_out_enable      <= 1'b0;
        end else begin
            periodic_irq_enable    <= next_periodic_irq_enable;
            alarm_irq_enable       <= next_alarm_irq_enable;
            update_done_irq_enable <= next_update_done_irq_enable;
            square_out_enable      <= next_square_out_enable;
        end
    end

    // bits the reset pin must not touch; only power-up gives them a value
    // reset immunity
    always_ff @(posedge ref_clk or negedge pwr_on_rstn) begin
        if (!pwr_on_rstn) begin
            update_freeze        <= 1'b0;
            number_format_select <= 1'b0;
            hour_24_select       <= 1'b0;
            summer_time_enable   <= 1'b0;
            rate_select          <= RCS_RATE_RESET;
            update_pending_flag  <= 1'b0;
            battery_valid        <= 1'b0;
            update_transfer_en   <= 1'b0;
        end else begin
            update_freeze        <= next_update_freeze;
            number_format_select <= next_number_format_select;
            hour_24_select       <= next_hour_24_select;
            summer_time_enable   <= next_summer_time_enable;
            rate_select          <= next_rate_select;
            update_pending_flag  <= next_update_pending_flag;
            battery_valid        <= battery_good;
            update_transfer_en   <= next_update_transfer_en;
        end
    end

    // ------------------------------------------------------------
    // flags, pending status and update transfer
    // ------------------------------------------------------------
    // a read clears flags, but an event in the same cycle still lands
    always_comb begin
        rd_flags  = bus_rd && (bus_addr == RCS_ADDR_FLAGS);
        alarm_hit = update_end && byte_match(alarm_sec, time_sec)
                    && byte_match(alarm_min, time_min)
                    && byte_match(alarm_hour, time_hour);
        next_periodic_flag    = tap_edge | (periodic_flag & ~rd_flags);
        next_alarm_match_flag = alarm_hit | (alarm_match_flag & ~rd_flags);
        next_update_done_flag = update_end | (update_done_flag & ~rd_flags);
        if (wr_control && bus_wdata[RCS_BIT_FREEZE]) begin
            next_update_pending_flag = 1'b0;
        end else if (update_start) begin
            next_update_pending_flag = 1'b1;
        end else if (update_end) begin
            next_update_pending_flag = 1'b0;
        end else begin
            next_update_pending_flag = update_pending_flag;
        end
        next_update_transfer_en = ~next_update_freeze;
        combined_request_flag = (periodic_flag & periodic_irq_enable)
                              | (alarm_match_flag & alarm_irq_enable)
                              | (update_done_flag & update_done_irq_enable);
        // pin changes on the same edge as the combined flag
        next_irq_n = ~((next_periodic_flag & next_periodic_irq_enable)
                     | (next_alarm_match_flag & next_alarm_irq_enable)
                     | (next_update_done_flag & next_update_done_irq_enable));
    end

    // flags drop on the reset pin
    // flag storage
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            periodic_flag    <= 1'b0;
            alarm_match_flag <= 1'b0;
            update_done_flag <= 1'b0;
            irq_n            <= 1'b1;
        end else begin
            periodic_flag    <= next_periodic_flag;
            alarm_match_flag <= next_alarm_match_flag;
            update_done_flag <= next_update_done_flag;
            irq_n            <= next_irq_n;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // unmapped reads give zero; in idle cycles data holds until the next read
    always_comb begin
        next_bus_rdata = bus_rdata;
        if (bus_rd) begin
            if (bus_addr == RCS_ADDR_RATE) begin
                next_bus_rdata = {update_pending_flag, 3'h0, rate_select};
            end else if (bus_addr == RCS_ADDR_CONTROL) begin
                next_bus_rdata = {update_freeze, periodic_irq_enable, alarm_irq_enable,
                                  update_done_irq_enable, square_out_enable,
                                  number_format_select, hour_24_select,
                                  summer_time_enable};
            end else if (bus_addr == RCS_ADDR_FLAGS) begin
                next_bus_rdata = {combined_request_flag, periodic_flag,
                                  alarm_match_flag, update_done_flag, 4'h0};
            end else if (bus_addr == RCS_ADDR_BATTERY) begin
                next_bus_rdata = {battery_valid, 7'h00};
            end else begin
                next_bus_rdata = RCS_BYTE_ZERO;
            end
        end
    end

    // read data register
    always_ff @(posedge ref_clk or negedge pwr_on_rstn) begin
        if (!pwr_on_rstn) begin
            bus_rdata <= RCS_BYTE_ZERO;
        end else begin
            bus_rdata <= next_bus_rdata;
        end
    end

endmodule : rcs_ctrl_regs

// ===== tb/rcs_ctrl_regs_asserts.sv
// rcs_ctrl_regs_asserts: port-level checks of the control/status registers
// assumes: bound into rcs_ctrl_regs, one clock, both resets active low
`timescale 1ns/100ps
module rcs_ctrl_regs_asserts
    import rcs_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       pwr_on_rstn,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [6:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic       osc_tick,
    input wire logic       update_end,
    input wire logic       irq_n,
    input wire logic       square_out_pin,
    input wire logic       update_transfer_en,
    input wire logic       number_format_select,
    input wire logic       hour_24_select,
    input wire logic       summer_time_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn || !pwr_on_rstn);
    // ------------------------------------------------------------
    // bus steps
    // ------------------------------------------------------------
    // control write whose masked byte equals v
    sequence ctrl_wr(logic [7:0] m, logic [7:0] v);
        bus_wr && bus_addr == RCS_ADDR_CONTROL && (bus_wdata & m) == v;
    endsequence
    // cycle with no write, then update end with no flag read beside it
    sequence upd_after;
        !bus_wr ##1 (update_end && !bus_rd);
    endsequence
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    rst_idle_a: assert property (disable iff (!pwr_on_rstn)
        !rstn |-> irq_n && !square_out_pin) else $error("reset pin left an output active");
    xfer_follow_a: assert property (ctrl_wr(8'h00, 8'h00) |=>
        update_transfer_en == !$past(bus_wdata[RCS_BIT_FREEZE])) else $error("transfer gate");
    fmt_copy_a: assert property (ctrl_wr(8'h00, 8'h00) |=>
        {number_format_select, hour_24_select, summer_time_enable} == $past(bus_wdata[2:0]))
        else $error("format copies wrong");
    upd_irq_a: assert property (ctrl_wr(8'h90, 8'h10) ##1 upd_after |=> !irq_n)
        else $error("update end did not raise irq");
    freeze_kill_a: assert property (ctrl_wr(8'hf0, 8'h90) ##0 update_transfer_en
        ##1 upd_after |=> irq_n) else $error("freeze kept update enable");
    read_release_a: assert property (bus_rd && bus_addr == RCS_ADDR_FLAGS && !update_end
        && !osc_tick && !$past(osc_tick) && !$past(osc_tick, 2) |=> irq_n)
        else $error("flag read did not release irq");
    quiet_en_a: assert property (ctrl_wr(8'h70, 8'h00) |=> irq_n)
        else $error("irq low with enables off");
    sq_off_a: assert property (ctrl_wr(8'h08, 8'h00) ##1 !bus_wr |=> !square_out_pin)
        else $error("square pin active while disabled");
    flag_nibble_a: assert property (bus_rd && bus_addr == RCS_ADDR_FLAGS |=>
        bus_rdata[3:0] == 4'h0) else $error("flag low nibble not zero");
    batt_low_a: assert property (bus_rd && bus_addr == RCS_ADDR_BATTERY |=>
        bus_rdata[6:0] == 7'h00) else $error("battery low bits not zero");
endmodule : rcs_ctrl_regs_asserts

// ===== tb/rcs_host_model.sv
// rcs_host_model: processor side of the register port, one access at a time
// assumes: the block samples strobes on the rising edge of ref_clk
`timescale 1ns/100ps
module rcs_host_model
    import rcs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] bus_rdata,
    output logic            bus_wr,
    output logic            bus_rd,
    output logic      [6:0] bus_addr,
    output logic      [7:0] bus_wdata
);
    // port idle at time zero
    initial begin
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_addr  = 7'h00;
        bus_wdata = 8'h00;
    end
    // one-cycle write strobe, address and data held through the sampling edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk); #1;
        bus_wr    = 1'b1;
        bus_addr  = a;
        bus_wdata = d;
        @(posedge ref_clk); #1;
        bus_wr    = 1'b0;
        // released data must not keep showing the written byte
        bus_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk); #1;
        bus_rd   = 1'b1;
        bus_addr = a;
        @(posedge ref_clk); #1;
        bus_rd   = 1'b0;
        d        = bus_rdata;
    endtask : rd
endmodule : rcs_host_model

// ===== tb/tb.sv
// tb: self-checking bench of the control/status register block
// assumes: host model owns the register port, bench drives events and resets
`timescale 1ns/100ps
module tb
    import rcs_pkg::*;
;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} rcs_row_t;
    // write byte, then expected read-back of the same place
    localparam rcs_row_t ROWS [8] = '{
        '{7'h0b, 8'h7e, 8'h7e}, '{7'h0b, 8'h01, 8'h01}, '{7'h0b, 8'h90, 8'h80},
        '{7'h0b, 8'h14, 8'h14}, '{7'h0a, 8'hff, 8'h0f}, '{7'h0c, 8'hff, 8'h00},
        '{7'h0d, 8'h00, 8'h80}, '{7'h7f, 8'hff, 8'h00}};
    logic        ref_clk      = 1'b0;
    logic        rstn         = 1'b0;
    logic        pwr_on_rstn  = 1'b0;
    logic [2:0]  ev           = 3'h0;        // update end, update start, oscillator tick
    logic [23:0] al           = 24'h000000;  // alarm hour, minute, second
    logic        battery_good = 1'b1;
    logic        bus_wr, bus_rd, irq_n, square_out_pin, update_transfer_en;
    logic [6:0]  bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, rv;
    logic        sq_hi, sq_lo, irq_lo;      // seen during a tick burst
    int          err_total = 0;
    int          n_tests   = 0;

    always #4 ref_clk = ~ref_clk;

    rcs_host_model i_host (.ref_clk, .bus_rdata, .bus_wr, .bus_rd, .bus_addr, .bus_wdata);
    rcs_ctrl_regs i_dut (.ref_clk, .rstn, .pwr_on_rstn, .bus_wr, .bus_rd, .bus_addr,
        .bus_wdata, .bus_rdata, .osc_tick(ev[0]), .update_start(ev[1]), .update_end(ev[2]),
        .time_sec(8'h56), .time_min(8'h34), .time_hour(8'h12), .alarm_sec(al[7:0]),
        .alarm_min(al[15:8]), .alarm_hour(al[23:16]), .battery_good, .irq_n,
        .square_out_pin, .update_transfer_en, .number_format_select(), .hour_24_select(),
        .summer_time_enable());

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk($sformatf("register %h", a), d, e);
    endtask : rdc
    // one-cycle pulse on event input k
    task automatic pulse(input int k);
        @(posedge ref_clk); #1;
        ev[k] = 1'b1;
        @(posedge ref_clk); #1;
        ev[k] = 1'b0;
    endtask : pulse
    // eight oscillator ticks; three idle cycles cover the flag latency
    task automatic tick8();
        sq_hi  = 1'b0;
        sq_lo  = 1'b0;
        irq_lo = 1'b0;
        repeat (8) begin
            pulse(0);
            sq_hi  |= square_out_pin;
            sq_lo  |= !square_out_pin;
            irq_lo |= !irq_n;
        end
        repeat (3) @(posedge ref_clk);
        #1;
        irq_lo |= !irq_n;
    endtask : tick8
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rstn        = 1'b1;
        pwr_on_rstn = 1'b1;
        foreach (ROWS[i]) begin
            i_host.wr(ROWS[i].a, ROWS[i].d);
            rdc(ROWS[i].a, ROWS[i].e);
        end
        // reset pin in mid-run: enables drop, format and rate stay
        i_host.wr(RCS_ADDR_CONTROL, 8'hef);
        @(posedge ref_clk); #1;
        rstn = 1'b0;
        @(posedge ref_clk); #1;
        chk("irq in reset", {7'h00, irq_n}, 8'h01);
        rstn = 1'b1;
        rdc(RCS_ADDR_CONTROL, 8'h87);
        rdc(RCS_ADDR_RATE, 8'h0f);
        battery_good = 1'b0;
        rdc(RCS_ADDR_BATTERY, 8'h00);
        battery_good = 1'b1;
        // update-ended interrupt and its release by a flag read
        i_host.wr(RCS_ADDR_CONTROL, 8'h10);
        pulse(2);
        chk("irq after update", {7'h00, irq_n}, 8'h00);
        rdc(RCS_ADDR_FLAGS, 8'h90);
        chk("irq after read", {7'h00, irq_n}, 8'h01);
        // alarm: masked with don't-care bytes, then exact match enabled
        i_host.wr(RCS_ADDR_CONTROL, 8'h00);
        al = {8'hc0, 8'hc0, 8'hc0};
        pulse(2);
        chk("irq alarm masked", {7'h00, irq_n}, 8'h01);
        rdc(RCS_ADDR_FLAGS, 8'h30);
        i_host.wr(RCS_ADDR_CONTROL, 8'h20);
        al = {8'h12, 8'h34, 8'h56};
        pulse(2);
        chk("irq alarm", {7'h00, irq_n}, 8'h00);
        rdc(RCS_ADDR_FLAGS, 8'hb0);
        // move the alarm off the fixed time so later update ends leave the alarm flag alone
        al = 24'h000000;
        // periodic flag and square output on the fastest tap
        i_host.wr(RCS_ADDR_CONTROL, 8'h08);
        i_host.wr(RCS_ADDR_RATE, 8'h03);
        tick8();
        chk("irq periodic masked", {7'h00, irq_lo}, 8'h00);
        chk("square swings", {6'h00, sq_hi, sq_lo}, 8'h03);
        rdc(RCS_ADDR_FLAGS, 8'h40);
        i_host.wr(RCS_ADDR_CONTROL, 8'h40);
        tick8();
        chk("irq periodic", {7'h00, irq_lo}, 8'h01);
        chk("square held low", {7'h00, sq_hi}, 8'h00);
        rdc(RCS_ADDR_FLAGS, 8'hc0);
        i_host.wr(RCS_ADDR_RATE, 8'h00);
        i_host.rd(RCS_ADDR_FLAGS, rv);
        tick8();
        rdc(RCS_ADDR_FLAGS, 8'h00);
        // pending flag, freeze write clears it and the update enable
        i_host.wr(RCS_ADDR_CONTROL, 8'h10);
        pulse(1);
        rdc(RCS_ADDR_RATE, 8'h80);
        i_host.wr(RCS_ADDR_CONTROL, 8'h90);
        pulse(2);
        chk("irq after freeze", {7'h00, irq_n}, 8'h01);
        rdc(RCS_ADDR_RATE, 8'h00);
        rdc(RCS_ADDR_FLAGS, 8'h10);
        chk("transfer frozen", {7'h00, update_transfer_en}, 8'h00);
        i_host.wr(RCS_ADDR_CONTROL, 8'h00);
        chk("transfer running", {7'h00, update_transfer_en}, 8'h01);
        // update end on the same edge as a flag read: the event survives
        fork
            i_host.rd(RCS_ADDR_FLAGS, rv);
            pulse(2);
        join
        chk("flags beside update", rv, 8'h00);
        rdc(RCS_ADDR_FLAGS, 8'h10);
        // slow codes: divider stands at 24; their taps first rise at counts 64 and 128
        i_host.wr(RCS_ADDR_RATE, 8'h01);
        repeat (39) pulse(0);
        rdc(RCS_ADDR_FLAGS, 8'h00);
        pulse(0);
        repeat (3) @(posedge ref_clk);
        rdc(RCS_ADDR_FLAGS, 8'h40);
        i_host.wr(RCS_ADDR_RATE, 8'h02);
        repeat (63) pulse(0);
        rdc(RCS_ADDR_FLAGS, 8'h00);
        pulse(0);
        repeat (3) @(posedge ref_clk);
        rdc(RCS_ADDR_FLAGS, 8'h40);
        complete_run();
    end
endmodule : tb

bind rcs_ctrl_regs rcs_ctrl_regs_asserts i_chk (.ref_clk, .rstn, .pwr_on_rstn, .bus_wr,
    .bus_rd, .bus_addr, .bus_wdata, .bus_rdata, .osc_tick, .update_end, .irq_n,
    .square_out_pin, .update_transfer_en, .number_format_select, .hour_24_select,
    .summer_time_enable);
